// ---- shared/scp_regs.svh ----
// register offsets, field positions and reset values of the serial client port
// assumes word-aligned 32-bit AHB-Lite register access
`ifndef SCP_REGS_SVH
`define SCP_REGS_SVH

`define SCP_OFS_BUF 8'h00
`define SCP_OFS_CON1 8'h04
`define SCP_OFS_CON3 8'h08
`define SCP_OFS_STAT 8'h0C

`define SCP_CON1_COLLIDE 7
`define SCP_CON1_OVERRUN 6
`define SCP_CON1_EN 5
`define SCP_CON1_IDLE_POL 4
`define SCP_STAT_SAMPLE_PHASE 7
`define SCP_STAT_CKE 6
`define SCP_STAT_FULL 0
`define SCP_CON3_OVERWRITE 4

`define SCP_MODE_CLIENT_SEL 4'h4
`define SCP_MODE_CLIENT_NOSEL 4'h5
`define SCP_CON1_RST 8'h00
`define SCP_CON3_RST 8'h00
`define SCP_STAT_RST 8'h00
`define SCP_BITS_PER_BYTE 3'h7

`endif

// ---- shared/scp_pkg.sv ----
// types of the serial client port
// assumes scp_regs.svh for numeric constants
package scp_pkg;
   typedef enum logic [1:0] {SCP_IDLE, SCP_SHIFT} scp_state_t;
endpackage : scp_pkg

// ---- rtl/scp_client_port.sv ----
// serial client port: spi client shifter with ahb-lite register slave
// assumes serial pins are asynchronous to ref_clk and sampled through two flops
// Notes on behaviour
// - shift only on external clock edges; flag
// - clock idle polarity chooses edge meaning
// - shifter independent of core; flag after eight
// - daisy chain: resend received bits next burst
// - overwrite enable allows buffer write unread
// - mode 0100 selects client with select pin
// - select low: shift and drive data out
// - select high releases data out after synchronisation
// - select high or disable clears counter
// - select fall starts fresh aligned byte
// - host mode freezes during sleep
// - client interrupt after host finishes data
// - full byte: copy buffer, set full, flag
// - write during shift dropped, sets collision
// - msb first out, lsb end in
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "scp_regs.svh"

// ----------------------------------------------------------------
// two-flop synchroniser for one asynchronous pin
// ----------------------------------------------------------------
module scp_sync2
   import scp_pkg::*;
#(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic async_in,
   output logic sync_out
);
   logic first_q;
   logic second_q;

   // only the second flop is seen outside, so metastability stays inside
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         first_q <= RESET_VALUE;
         second_q <= RESET_VALUE;
      end else begin
         first_q <= async_in;
         second_q <= first_q;
      end
   end
   assign sync_out = second_q;

endmodule : scp_sync2

module scp_client_port
   import scp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic serial_clock_pin,
   input wire logic serial_data_in,
   input wire logic client_select_n,
   output logic serial_data_out,
   output logic serial_data_out_oe,
   output logic port_irq_flag
);

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // the link runs on the host's clock, so every pin is resynchronised here;
   // the link clock must stay high and low for at least three ref_clk cycles
   logic sck_sync;
   logic sdi_sync;
   logic sel_sync;
   logic sck_prev_q;

   scp_sync2 #(.RESET_VALUE(1'b0)) scp_sync2_sck_inst (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in(serial_clock_pin),
      .sync_out(sck_sync)
   );

   scp_sync2 #(.RESET_VALUE(1'b0)) scp_sync2_sdi_inst (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in(serial_data_in),
      .sync_out(sdi_sync)
   );

   // select resets deasserted, so no false frame start follows reset
   scp_sync2 #(.RESET_VALUE(1'b1)) scp_sync2_sel_inst (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .async_in(client_select_n),
      .sync_out(sel_sync)
   );

   // previous synchronised clock level, for edge detection
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sck_prev_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_sync;
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] con1_q;
   logic [7:0] con3_q;
   logic [1:0] stat_hi_q;
   logic [7:0] buf_q;
   logic buf_full_q;
   logic irq_q;
   logic [7:0] sr_q;
   logic [2:0] cnt_q;
   scp_state_t state_q;

   logic port_en;
   logic idle_pol;
   logic cke;
   logic sel_mode;
   logic client_mode;
   logic sel_high;
   logic hold_reset;
   logic sck_now;
   logic lead_edge;
   logic trail_edge;
   logic sample_edge;
   logic shift_edge;
   logic byte_done;

   assign port_en = con1_q[`SCP_CON1_EN];
   assign idle_pol = con1_q[`SCP_CON1_IDLE_POL];
   assign cke = stat_hi_q[0];
   assign sel_mode = con1_q[3:0] == `SCP_MODE_CLIENT_SEL;
   assign client_mode = sel_mode || (con1_q[3:0] == `SCP_MODE_CLIENT_NOSEL);
   assign sel_high = sel_mode && sel_sync;
   // host modes have no rate generator here: the engine stays parked and
   // nothing shifts, so no host transfer can advance while the core sleeps
   assign hold_reset = !port_en || !client_mode || sel_high;
   // clock level relative to idle: leaving idle is the leading edge
   assign sck_now = sck_sync ^ idle_pol;
   assign lead_edge = sck_now && !(sck_prev_q ^ idle_pol);
   assign trail_edge = !sck_now && (sck_prev_q ^ idle_pol);
   // cke=1: output on active-to-idle, sample on idle-to-active
   assign sample_edge = cke ? lead_edge : trail_edge;
   assign shift_edge = cke ? trail_edge : lead_edge;
   assign byte_done = sample_edge && !hold_reset && (cnt_q == `SCP_BITS_PER_BYTE);

   // ----------------------------------------------------------------
   // ahb-lite slave
   // ----------------------------------------------------------------
   logic wr_pend_q;
   logic rd_pend_q;
   logic [7:0] addr_q;
   logic [31:0] rdata_q;
   logic addr_phase;
   logic buf_wr;
   logic buf_rd;
   logic busy;

   // zero wait states: every transfer completes in its data phase
   assign addr_phase = hsel && hready && htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;
   assign buf_wr = wr_pend_q && (addr_q == `SCP_OFS_BUF);
   assign buf_rd = addr_phase && !hwrite && (haddr[7:0] == `SCP_OFS_BUF);
   assign busy = state_q == SCP_SHIFT;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_phase && hwrite;
         rd_pend_q <= addr_phase && !hwrite;
         addr_q <= addr_phase ? {haddr[7:2], 2'h0} : addr_q;
      end
   end

   // read data is registered at the address phase, valid in the data phase
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdata_q <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         case ({haddr[7:2], 2'h0})
            `SCP_OFS_BUF: rdata_q <= {24'h00_0000, buf_q};
            `SCP_OFS_CON1: rdata_q <= {24'h00_0000, con1_q};
            `SCP_OFS_CON3: rdata_q <= {24'h00_0000, con3_q};
            `SCP_OFS_STAT: rdata_q <= {24'h00_0000, stat_hi_q, 5'h00, buf_full_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // a buffer write is taken unless shifting is under way, collision pends, or the buffer is full with overwrite off
   logic wr_ok;
   // a refused write never reaches the shifter, so a frame in flight is safe
   assign wr_ok = !busy && !con1_q[`SCP_CON1_COLLIDE] &&
                  (!buf_full_q || con3_q[`SCP_CON3_OVERWRITE]);

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         con1_q <= `SCP_CON1_RST;
      end else begin
         if (wr_pend_q && addr_q == `SCP_OFS_CON1) begin
            con1_q <= hwdata[7:0];
         end
         // hardware set wins over a simultaneous software clear
         if (buf_wr && !wr_ok && busy) begin
            con1_q[`SCP_CON1_COLLIDE] <= 1'b1;
         end
         // a byte landing on an unread buffer marks an overrun unless overwrite is enabled
         if (byte_done && buf_full_q && !con3_q[`SCP_CON3_OVERWRITE]) begin
            con1_q[`SCP_CON1_OVERRUN] <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         con3_q <= `SCP_CON3_RST;
         stat_hi_q <= 2'h0;
      end else if (wr_pend_q) begin
         if (addr_q == `SCP_OFS_CON3) begin
            con3_q <= hwdata[7:0];
         end
         if (addr_q == `SCP_OFS_STAT) begin
            stat_hi_q <= hwdata[7:6];
         end
      end
   end

   // ----------------------------------------------------------------
   // shift engine
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cnt_q <= 3'h0;
         state_q <= SCP_IDLE;
      end else if (hold_reset) begin
         cnt_q <= 3'h0;
         state_q <= SCP_IDLE;
      end else if (sample_edge) begin
         cnt_q <= cnt_q + 3'h1; // wraps to zero after eight bits
         case (state_q)
            SCP_IDLE: state_q <= byte_done ? SCP_IDLE : SCP_SHIFT;
            SCP_SHIFT: state_q <= byte_done ? SCP_IDLE : SCP_SHIFT;
            default: state_q <= SCP_IDLE;
         endcase
      end
   end

   // received bit enters at lsb; the byte sent next is what came in
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sr_q <= 8'h00;
      end else if (buf_wr && wr_ok) begin
         sr_q <= hwdata[7:0];
      end else if (sample_edge && !hold_reset) begin
         sr_q <= {sr_q[6:0], sdi_sync};
      end
   end

   // output bit: msb presented, advanced on the shift edge
   logic sdo_q;
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         sdo_q <= 1'b0;
      end else if (buf_wr && wr_ok) begin
         sdo_q <= hwdata[7];
      end else if (hold_reset) begin
         sdo_q <= sr_q[7];
      end else if (shift_edge || (cke == 1'b0 && sample_edge && cnt_q == 3'h0)) begin
         sdo_q <= sr_q[7];
      end
   end
   assign serial_data_out = sdo_q;
   // select mode: drive only while selected; mode 0101: whenever enabled
   // release follows the synchronised select, one to two cycles late
   assign serial_data_out_oe = port_en && client_mode &&
                               !(sel_mode && sel_sync);

   // ----------------------------------------------------------------
   // receive buffer and flags
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         buf_q <= 8'h00;
      end else if (byte_done) begin
         // the last bit is taken straight from the pin path, not the shifter
         buf_q <= {sr_q[6:0], sdi_sync};
      end else if (buf_wr && wr_ok) begin
         buf_q <= hwdata[7:0];
      end
   end

   // full flag: a new byte wins over a read of the buffer in the same cycle
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         buf_full_q <= 1'b0;
      end else if (byte_done) begin
         buf_full_q <= 1'b1;
      end else if (buf_rd) begin
         buf_full_q <= 1'b0;
      end
   end

   // port flag: set per byte, cleared by writing 1 to status bit 1
   logic irq_clr;
   assign irq_clr = wr_pend_q && addr_q == `SCP_OFS_STAT && hwdata[1];
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else if (byte_done) begin
         irq_q <= 1'b1;
      end else if (irq_clr) begin
         irq_q <= 1'b0;
      end
   end
   assign port_irq_flag = irq_q;

endmodule : scp_client_port

// ---- testbench/scp_client_port_monitor.sv ----
// checker: pin and bus relations of the serial client port
// assumes a bind onto the top module; serial pins arrive raw
`timescale 1ns/1ps
module scp_client_port_monitor (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic serial_clock_pin,
   input wire logic client_select_n,
   input wire logic serial_data_out,
   input wire logic serial_data_out_oe,
   input wire logic port_irq_flag
);
   // ----
   // cycles since the last link clock change and the last bus write
   // ----
   logic clk_seen_q;
   logic [3:0] edge_age_q;
   logic [3:0] wr_age_q;
   always_ff @(posedge ref_clk) begin
      clk_seen_q <= serial_clock_pin;
      if (!nrst || serial_clock_pin != clk_seen_q) edge_age_q <= 4'h0;
      else if (edge_age_q != 4'hF) edge_age_q <= edge_age_q + 4'h1;
   end
   always_ff @(posedge ref_clk) begin
      if (!nrst) wr_age_q <= 4'hF;
      else if (hsel && htrans[1] && hwrite) wr_age_q <= 4'h0;
      else if (wr_age_q != 4'hF) wr_age_q <= wr_age_q + 4'h1;
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence sel_high_s; client_select_n [*4]; endsequence
   sequence irq_rise_s; $rose(port_irq_flag); endsequence
   chk_oe_release: assert property (sel_high_s |-> !serial_data_out_oe)
      else $error("data out driven while deselected");
   chk_oe_start: assert property (
      $rose(serial_data_out_oe) |-> !client_select_n && !$past(client_select_n))
      else $error("data out driven without select");
   chk_irq_edge: assert property (irq_rise_s |-> edge_age_q <= 4'h7)
      else $error("flag raised without a link clock edge");
   chk_irq_sync: assert property (irq_rise_s |-> edge_age_q >= 4'h2)
      else $error("flag raised before synchronisation");
   chk_sdo_cause: assert property (
      $changed(serial_data_out) && serial_data_out_oe && $past(serial_data_out_oe)
      |-> edge_age_q <= 4'h7 || wr_age_q <= 4'h4) else $error("data out moved alone");
   chk_irq_hold: assert property ($fell(port_irq_flag) |-> wr_age_q <= 4'h4)
      else $error("flag dropped without a write");
   chk_resp_okay: assert property (hresp == 1'b0)
      else $error("bus response not okay");
   chk_ready_high: assert property (hreadyout == 1'b1)
      else $error("bus wait state inserted");
endmodule : scp_client_port_monitor

// ---- testbench/scp_spi_host_model.sv ----
// link host: drives clock, select and data in; samples the data out line
// assumes clock idle low, client samples leading edge and shifts on trailing
`timescale 1ns/1ps
module scp_spi_host_model (
   output logic serial_clock_pin,
   output logic serial_data_in,
   output logic client_select_n,
   input wire logic serial_data_out
);
   initial begin
      serial_clock_pin = 1'b0;
      serial_data_in = 1'b0;
      client_select_n = 1'b1;
   end
   // clock stands still outside frames; n below eight aborts mid-byte
   task automatic xfer(input int n, input logic [7:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      #7 client_select_n = 1'b0;
      #400;
      for (int i = 7; i > 7 - n; i--) begin
         serial_data_in = tx[i];
         #90 serial_clock_pin = 1'b1;
         #90 rx[i] = serial_data_out;
         #10 serial_clock_pin = 1'b0;
         #10;
      end
      #400 client_select_n = 1'b1;
      serial_data_in = ~serial_data_in;
      #400;
   endtask : xfer
endmodule : scp_spi_host_model

// ---- testbench/scp_client_port_tb_top.sv ----
// bench: drives the serial client port over ahb-lite and a modelled link host
// assumes scp_regs.svh on the include path
`timescale 1ns/1ps
`include "scp_regs.svh"
module scp_client_port_tb_top;
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rv;
   logic hreadyout, hresp, sck, din, sel_n, dout, dout_oe, irq;
   logic [7:0] rx;
   wire logic line_w = dout_oe ? dout : 1'bz;
   int n_fail = 0;
   int num_checks = 0;
   int cyc = 0;
   always #12.5 ref_clk = ~ref_clk;
   scp_client_port scp_client_port_inst (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .serial_clock_pin(sck), .serial_data_in(din), .client_select_n(sel_n),
      .serial_data_out(dout), .serial_data_out_oe(dout_oe), .port_irq_flag(irq));
   scp_spi_host_model scp_spi_host_model_inst (.serial_clock_pin(sck),
      .serial_data_in(din), .client_select_n(sel_n), .serial_data_out(line_w));
   // ----
   // shared tasks
   // ----
   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rv = hrdata;
   endtask : bus
   task automatic link(input int n, input logic [7:0] tx);
      scp_spi_host_model_inst.xfer(n, tx, rx);
   endtask : link
   // ----
   // scenarios
   // ----
   task automatic t_regs;
      logic [7:0] a[4] = '{`SCP_OFS_CON1, `SCP_OFS_CON3, `SCP_OFS_STAT, 8'h10};
      foreach (a[i]) begin
         bus(1'b0, a[i], 32'h0);
         chk("reset value", 32'h0, rv);
      end
      $display("test regs done");
   endtask : t_regs
   task automatic t_xfer;
      bus(1'b1, `SCP_OFS_STAT, 32'h40);
      bus(1'b1, `SCP_OFS_CON1, 32'h24);
      bus(1'b1, `SCP_OFS_BUF, 32'hA5);
      link(8, 8'h3C);
      chk("sent byte", 32'hA5, 32'(rx));
      chk("irq", 32'h1, 32'(irq));
      bus(1'b0, `SCP_OFS_STAT, 32'h0);
      chk("status", 32'h41, rv);
      bus(1'b0, `SCP_OFS_BUF, 32'h0);
      chk("received", 32'h3C, rv);
      link(8, 8'h00);
      chk("chained", 32'h3C, 32'(rx));
      bus(1'b1, `SCP_OFS_STAT, 32'h42);
      @(negedge ref_clk);
      chk("irq clear", 32'h0, 32'(irq));
      bus(1'b0, `SCP_OFS_BUF, 32'h0);
      $display("test xfer done");
   endtask : t_xfer
   task automatic t_abort;
      link(3, 8'hE0);
      chk("released", 32'h0, 32'(dout_oe));
      bus(1'b0, `SCP_OFS_STAT, 32'h0);
      chk("no byte", 32'h40, rv);
      link(8, 8'h96);
      bus(1'b0, `SCP_OFS_BUF, 32'h0);
      chk("realigned", 32'h96, rv);
      $display("test abort done");
   endtask : t_abort
   task automatic t_collide;
      fork
         link(8, 8'h5A);
         begin #1200; bus(1'b1, `SCP_OFS_BUF, 32'h11); end
      join
      chk("write dropped", 32'h96, 32'(rx));
      bus(1'b0, `SCP_OFS_CON1, 32'h0);
      chk("collision", 32'hA4, rv);
      bus(1'b1, `SCP_OFS_CON1, 32'h24);
      bus(1'b1, `SCP_OFS_CON3, 32'h10);
      bus(1'b1, `SCP_OFS_BUF, 32'hC3);
      link(8, 8'h00);
      chk("overwrite", 32'hC3, 32'(rx));
      $display("test collide done");
   endtask : t_collide
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         conclude;
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      t_regs;
      t_xfer;
      t_abort;
      t_collide;
      conclude;
   end
endmodule : scp_client_port_tb_top
bind scp_client_port scp_client_port_monitor scp_client_port_monitor_inst (
   .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hreadyout(hreadyout), .hresp(hresp), .serial_clock_pin(serial_clock_pin),
   .client_select_n(client_select_n), .serial_data_out(serial_data_out),
   .serial_data_out_oe(serial_data_out_oe), .port_irq_flag(port_irq_flag));
